// ---- verilog/poc_pkg.sv ----
// Package of constants, types and the register map of the PID output controller.
package poc_pkg;
	localparam int CLK_MHZ        = 50;
	localparam int SAMPLE_US      = 1000;
	localparam int SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;
	localparam int MINUTE_S       = 60;
	localparam int MINUTE_SAMPLES = MINUTE_S * 1000000 / SAMPLE_US;
	localparam int SHOW_MS        = 2000;
	localparam int SHOW_SAMPLES   = SHOW_MS * 1000 / SAMPLE_US;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_KP   = 8'h08;
	localparam logic [7:0] A_TR   = 8'h0C;
	localparam logic [7:0] A_TD   = 8'h10;
	localparam logic [7:0] A_SP   = 8'h14;
	localparam logic [7:0] A_MAN  = 8'h18;
	localparam logic [7:0] A_SAFE = 8'h1C;
	localparam logic [7:0] A_RATE = 8'h20;
	localparam logic [7:0] A_LOL  = 8'h24;
	localparam logic [7:0] A_HIL  = 8'h28;
	localparam logic [7:0] A_LRV  = 8'h2C;
	localparam logic [7:0] A_URV  = 8'h30;
	localparam logic [7:0] A_CALL = 8'h34;
	localparam logic [7:0] A_CALH = 8'h38;
	localparam logic [7:0] A_SPAN = 8'h3C;
	localparam logic [7:0] A_MON  = 8'h40;
	localparam logic [7:0] A_PCT  = 8'h44;
	localparam logic [7:0] A_OUT  = 8'h48;
	localparam logic [7:0] A_TIME = 8'h4C;
	localparam logic [7:0] A_TBL  = 8'h80;
	localparam int B_PID = 0, B_REV = 1, B_MAN = 2, B_TRK = 3, B_GEN = 4, B_LIN = 5;
	localparam int B_RERR = 0, B_FAIL = 1, B_SAFE = 2;
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [15:0] KP_RST = 16'h0100;
	localparam logic [15:0] PCT_FULL = 16'h2710;
	localparam logic [15:0] RANGE_UP_RST = 16'h0064;
	localparam logic [15:0] CAL_LO_RST = 16'hF060;
	localparam logic [15:0] CAL_HI_RST = 16'h0FA0;
	localparam logic [15:0] SPAN_RST = 16'h000A;
	localparam logic [15:0] CUR_LOW_UA = 16'h0FA0;
	localparam int CUR_NUM = 8, CUR_DEN = 5, KP_SHIFT = 8;
	localparam logic signed [31:0] INTEG_MAX = 32'sh00FFFFFF;
	typedef enum logic [1:0] {PWR_AUTO = 2'b00, PWR_MAN = 2'b01, PWR_LAST = 2'b10} poc_pwr_t;
	typedef enum logic [3:0] {
		MON_NONE = 4'h0, MON_CUR = 4'h1, MON_MV = 4'h2, MON_PV = 4'h3, MON_TEMP = 4'h4,
		MON_PVP = 4'h5, MON_SPP = 4'h6, MON_SP = 4'h7, MON_TIME = 4'h8, MON_ERR = 4'h9
	} poc_mon_t;
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} poc_avs_req_t;
endpackage

// ---- verilog/poc_top.sv ----
// PID output controller with range scaling, setpoint generator and monitor selection.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
// How it works
// RQ1: Enabled control computes gain times error, integral over reset time, derivative term.
// RQ2: Error is process minus setpoint when direct, setpoint minus process when reverse.
// RQ3: Control disabled makes output follow scaled process value as a transmitter.
// RQ4: Manual with tracking copies process value into setpoint every cycle.
// RQ5: Leaving manual with tracking keeps the last copied process value as setpoint.
// RQ6: Automatic and manual modes; manual output is the operator-written value.
// RQ7: Power-up mode is automatic, manual, or the mode held before power loss.
// RQ8: Safety value drives output after power-up and while a failure lasts.
// RQ9: In automatic control, output change per update is limited to the configured rate.
// RQ10: Outside transmitter mode and safety value, output percentage is clamped to never fall below the lower limit unless the upper limit is set below it.
// RQ11: Outside transmitter mode and safety value, output percentage is clamped to never exceed the upper limit.
// RQ12: Active generator steps setpoint through a minute-timed percent table.
// RQ13: Monitor alternates two selections, steady when equal or second is none.
// RQ14: Control-only monitor choices are accepted only with control enabled.
// RQ15: Error monitor value is setpoint percent minus process percent.
// RQ16: In transmitter mode lower range gives 4 mA and upper range 20 mA.
// RQ17: In control mode lower range is 0 % and upper range 100 % process.
// RQ18: Writing one range value leaves the other one unchanged.
// RQ19: A range value is accepted only inside the sensor calibration limits.
// RQ20: A range change needs range difference above the minimum span.
// RQ21: To reverse, configurer moves one value near the other, then writes both.
// RQ22: Custom linearization and setpoint generator are never active together.
// RQ23: Control law runs at a fixed sample period with summed integral and differenced derivative.
// RQ24: Output percentage maps linearly to loop current from low end to high end.
module poc_top
	import poc_pkg::*;
#(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC,
	parameter int MIN_SAMPLES   = MINUTE_SAMPLES,
	parameter int SHOW_TICKS    = SHOW_SAMPLES
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire poc_avs_req_t avs_req,
	output logic              avs_waitrequest,
	output logic [31:0]       avs_readdata,
	input  wire logic [15:0]  process_value,
	input  wire logic [15:0]  room_temp,
	input  wire logic         sensor_fail,
	input  wire logic [1:0]   nv_pwr_mode,
	input  wire logic         nv_manual,
	output logic              mode_manual,
	output logic [15:0]       manipulated_output,
	output logic [15:0]       loop_current_ua,
	output logic [3:0]        monitor_function,
	output logic [15:0]       monitor_value
);
	function automatic logic signed [31:0] clamp(input logic signed [47:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		if (v < 48'(lo))
			clamp = lo;
		else if (v > 48'(hi))
			clamp = hi;
		else
			clamp = v[31:0];
	endfunction

	function automatic logic signed [31:0] sx(input logic [15:0] v);
		sx = 32'(signed'(v));
	endfunction

	function automatic logic pid_only(input logic [3:0] s);
		pid_only = (s == MON_MV) || (s == MON_SPP) || (s == MON_SP) ||
			(s == MON_TIME) || (s == MON_ERR);
	endfunction

	logic [5:0]  ctrl_reg;
	logic        manual_reg, boot_reg, powerup_reg, rerr_reg, ack_reg;
	logic [15:0] kp_reg, tr_reg, td_reg, sp_reg, man_reg, safe_reg, rate_reg;
	logic [15:0] lol_reg, hil_reg, lrv_reg, urv_reg, call_reg, calh_reg, span_reg;
	logic [15:0] mv_reg, cur_reg, pvp_reg, pv_prev_reg, gtime_reg, mval_reg;
	logic [3:0]  mon1_reg, mon2_reg, msel_reg, gidx_reg;
	logic [31:0] tbl_mem [16];
	logic [31:0] rdata_reg;
	logic signed [31:0] integ_reg;
	logic [31:0] tick_cnt_reg, min_cnt_reg, show_cnt_reg;
	logic        tick, wr_en, rd_en, show_second;
	logic signed [31:0] pv_pct, sp_pct, err, integ_next, u_next, mv_next, step;
	logic signed [47:0] law;
	logic signed [31:0] new_span, span_abs;
	logic        range_ok;
	logic [15:0] rng_val;

	// A request is answered one cycle after it appears; writes land on that edge.
	assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_reg;
	assign wr_en = avs_req.write & ack_reg;
	assign rd_en = avs_req.read & ~ack_reg;
	assign avs_readdata = rdata_reg;
	assign mode_manual = manual_reg;
	assign manipulated_output = mv_reg;
	assign loop_current_ua = cur_reg;
	assign monitor_function = msel_reg;
	assign monitor_value = mval_reg;
	assign tick = (tick_cnt_reg == 32'(SAMPLE_CYCLES - 1));

	always_ff @(posedge mclk) begin
		if (!rstn)
			ack_reg <= 1'b0;
		else
			ack_reg <= (avs_req.read | avs_req.write) & ~ack_reg;
	end

	always_ff @(posedge mclk) begin
		if (!rstn || tick)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + 32'd1;
	end

	always_comb begin
		pv_pct = 32'(((48'(sx(process_value)) - 48'(sx(lrv_reg))) * 48'(sx(PCT_FULL))) /
			(48'(sx(urv_reg)) - 48'(sx(lrv_reg)))); // RQ17 RQ16
		sp_pct = sx(sp_reg);
		if (ctrl_reg[B_REV])
			err = sp_pct - pv_pct; // RQ2
		else
			err = pv_pct - sp_pct; // RQ2
		integ_next = clamp(48'(integ_reg) + 48'(err), -INTEG_MAX, INTEG_MAX); // RQ23
		law = 48'(err) + 48'(sx(td_reg)) * (48'(pv_pct) - 48'(sx(pv_prev_reg))); // RQ23
		if (tr_reg != 16'h0000)
			law = law + 48'(integ_next / $signed({16'h0000, tr_reg})); // RQ1
		law = (law * $signed({32'h0000_0000, kp_reg})) >>> KP_SHIFT; // RQ1
		u_next = clamp(law, 32'sd0, 32'(PCT_FULL));
		step = u_next - sx(mv_reg);
		if (step > $signed({16'h0000, rate_reg}))
			u_next = sx(mv_reg) + $signed({16'h0000, rate_reg}); // RQ9
		else if (step < -$signed({16'h0000, rate_reg}))
			u_next = sx(mv_reg) - $signed({16'h0000, rate_reg}); // RQ9
		if (manual_reg)
			mv_next = sx(man_reg); // RQ6
		else
			mv_next = u_next; // RQ1
		mv_next = clamp(48'(mv_next), sx(lol_reg), 32'(PCT_FULL)); // RQ10
		mv_next = clamp(48'(mv_next), 32'sd0, sx(hil_reg)); // RQ11
		if (!ctrl_reg[B_PID])
			mv_next = clamp(48'(pv_pct), 32'sd0, 32'(PCT_FULL)); // RQ3
		if (powerup_reg || sensor_fail)
			mv_next = sx(safe_reg); // RQ8
	end

	// Range writes are checked against the calibration limits and the span.
	always_comb begin
		rng_val = avs_req.writedata[15:0];
		if (avs_req.address == A_LRV)
			new_span = sx(urv_reg) - sx(rng_val);
		else
			new_span = sx(rng_val) - sx(lrv_reg);
		span_abs = (new_span < 0) ? -new_span : new_span;
		range_ok = (sx(rng_val) >= sx(call_reg)) && (sx(rng_val) <= sx(calh_reg)) && // RQ19
			(span_abs > sx(span_reg)); // RQ20
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			lrv_reg <= 16'h0000;
			urv_reg <= RANGE_UP_RST;
			rerr_reg <= 1'b0;
		end else begin
			if (wr_en && (avs_req.address == A_LRV) && range_ok)
				lrv_reg <= rng_val; // RQ18
			if (wr_en && (avs_req.address == A_URV) && range_ok)
				urv_reg <= rng_val; // RQ18
			if (wr_en && (avs_req.address == A_LRV || avs_req.address == A_URV) && !range_ok)
				rerr_reg <= 1'b1;
			else if (wr_en && avs_req.address == A_STAT && avs_req.writedata[B_RERR])
				rerr_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RST;
			powerup_reg <= 1'b1;
		end else if (wr_en && avs_req.address == A_CTRL) begin
			ctrl_reg <= avs_req.writedata[5:0];
			if (avs_req.writedata[B_GEN] && avs_req.writedata[B_LIN])
				ctrl_reg[B_GEN] <= 1'b0; // RQ22
			if (avs_req.writedata[B_GEN] && ctrl_reg[B_LIN] && !avs_req.writedata[B_LIN])
				ctrl_reg[B_GEN] <= 1'b0; // RQ22
			if (avs_req.writedata[B_LIN] && ctrl_reg[B_GEN])
				ctrl_reg[B_LIN] <= 1'b0; // RQ22
			powerup_reg <= 1'b0; // RQ8
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			manual_reg <= 1'b0;
			boot_reg <= 1'b1;
		end else if (boot_reg) begin
			boot_reg <= 1'b0;
			case (poc_pwr_t'(nv_pwr_mode))
				PWR_AUTO: manual_reg <= 1'b0; // RQ7
				PWR_MAN:  manual_reg <= 1'b1; // RQ7
				PWR_LAST: manual_reg <= nv_manual; // RQ7
				default:  manual_reg <= 1'b0;
			endcase
		end else if (wr_en && avs_req.address == A_CTRL) begin
			manual_reg <= avs_req.writedata[B_MAN]; // RQ6
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			kp_reg <= KP_RST;
			tr_reg <= 16'h0000;
			td_reg <= 16'h0000;
			man_reg <= 16'h0000;
			safe_reg <= 16'h0000;
			rate_reg <= PCT_FULL;
			lol_reg <= 16'h0000;
			hil_reg <= PCT_FULL;
			call_reg <= CAL_LO_RST;
			calh_reg <= CAL_HI_RST;
			span_reg <= SPAN_RST;
		end else if (wr_en) begin
			case (avs_req.address)
				A_KP:    kp_reg <= avs_req.writedata[15:0];
				A_TR:    tr_reg <= avs_req.writedata[15:0];
				A_TD:    td_reg <= avs_req.writedata[15:0];
				A_MAN:   man_reg <= avs_req.writedata[15:0];
				A_SAFE:  safe_reg <= avs_req.writedata[15:0];
				A_RATE:  rate_reg <= avs_req.writedata[15:0];
				A_LOL:   lol_reg <= avs_req.writedata[15:0];
				A_HIL:   hil_reg <= avs_req.writedata[15:0];
				A_CALL:  call_reg <= avs_req.writedata[15:0];
				A_CALH:  calh_reg <= avs_req.writedata[15:0];
				A_SPAN:  span_reg <= avs_req.writedata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (wr_en && avs_req.address[7:6] == A_TBL[7:6])
			tbl_mem[avs_req.address[5:2]] <= avs_req.writedata;
	end

	// Generator time counts whole minutes from its enable; the index walks the table.
	always_ff @(posedge mclk) begin
		if (!rstn || !ctrl_reg[B_GEN]) begin
			min_cnt_reg <= '0;
			gtime_reg <= 16'h0000;
			gidx_reg <= 4'h0;
		end else if (tick) begin
			if (min_cnt_reg == 32'(MIN_SAMPLES - 1)) begin
				min_cnt_reg <= '0;
				gtime_reg <= gtime_reg + 16'h0001; // RQ12
			end else begin
				min_cnt_reg <= min_cnt_reg + 32'd1;
			end
			if (gidx_reg != 4'hF && gtime_reg >= tbl_mem[gidx_reg + 4'h1][31:16])
				gidx_reg <= gidx_reg + 4'h1; // RQ12
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn)
			sp_reg <= 16'h0000;
		else if (ctrl_reg[B_GEN])
			sp_reg <= tbl_mem[gidx_reg][15:0]; // RQ12
		else if (manual_reg && ctrl_reg[B_TRK])
			sp_reg <= pv_pct[15:0]; // RQ4 RQ5
		else if (wr_en && avs_req.address == A_SP)
			sp_reg <= avs_req.writedata[15:0];
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mv_reg <= 16'h0000;
			integ_reg <= '0;
			pv_prev_reg <= 16'h0000;
			pvp_reg <= 16'h0000;
			cur_reg <= CUR_LOW_UA;
		end else if (tick) begin
			mv_reg <= mv_next[15:0];
			pv_prev_reg <= pv_pct[15:0]; // RQ23
			pvp_reg <= pv_pct[15:0];
			if (ctrl_reg[B_PID] && !manual_reg)
				integ_reg <= integ_next; // RQ23
			cur_reg <= CUR_LOW_UA + 16'((mv_next * CUR_NUM) / CUR_DEN); // RQ24 RQ16
		end
	end

	// Monitor selections; control-only choices are refused in transmitter mode.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mon1_reg <= MON_PVP;
			mon2_reg <= MON_CUR;
		end else if (wr_en && avs_req.address == A_MON) begin
			if (ctrl_reg[B_PID] || !pid_only(avs_req.writedata[3:0]))
				mon1_reg <= avs_req.writedata[3:0]; // RQ14
			if (ctrl_reg[B_PID] || !pid_only(avs_req.writedata[7:4]))
				mon2_reg <= avs_req.writedata[7:4]; // RQ14
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			show_cnt_reg <= '0;
			show_second <= 1'b0;
		end else if (mon2_reg == MON_NONE || mon2_reg == mon1_reg) begin
			show_second <= 1'b0; // RQ13
		end else if (tick) begin
			if (show_cnt_reg == 32'(SHOW_TICKS - 1)) begin
				show_cnt_reg <= '0;
				show_second <= ~show_second; // RQ13
			end else begin
				show_cnt_reg <= show_cnt_reg + 32'd1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			msel_reg <= MON_NONE;
			mval_reg <= 16'h0000;
		end else begin
			msel_reg <= show_second ? mon2_reg : mon1_reg;
			case (poc_mon_t'(show_second ? mon2_reg : mon1_reg))
				MON_CUR:  mval_reg <= cur_reg;
				MON_MV:   mval_reg <= mv_reg;
				MON_PV:   mval_reg <= process_value;
				MON_TEMP: mval_reg <= room_temp;
				MON_PVP:  mval_reg <= pvp_reg;
				MON_SPP:  mval_reg <= sp_reg;
				MON_SP:   mval_reg <= 16'(sx(lrv_reg) + (sp_pct * (sx(urv_reg) - sx(lrv_reg))) /
					sx(PCT_FULL));
				MON_TIME: mval_reg <= gtime_reg;
				MON_ERR:  mval_reg <= sp_reg - pvp_reg; // RQ15
				default:  mval_reg <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rdata_reg <= '0;
		end else if (rd_en) begin
			case (avs_req.address)
				A_CTRL:  rdata_reg <= {26'h0, ctrl_reg[5:3], manual_reg, ctrl_reg[1:0]};
				A_STAT:  rdata_reg <= {29'h0, powerup_reg | sensor_fail, sensor_fail, rerr_reg};
				A_KP:    rdata_reg <= {16'h0, kp_reg};
				A_TR:    rdata_reg <= {16'h0, tr_reg};
				A_TD:    rdata_reg <= {16'h0, td_reg};
				A_SP:    rdata_reg <= {16'h0, sp_reg};
				A_MAN:   rdata_reg <= {16'h0, man_reg};
				A_SAFE:  rdata_reg <= {16'h0, safe_reg};
				A_RATE:  rdata_reg <= {16'h0, rate_reg};
				A_LOL:   rdata_reg <= {16'h0, lol_reg};
				A_HIL:   rdata_reg <= {16'h0, hil_reg};
				A_LRV:   rdata_reg <= {16'h0, lrv_reg};
				A_URV:   rdata_reg <= {16'h0, urv_reg};
				A_CALL:  rdata_reg <= {16'h0, call_reg};
				A_CALH:  rdata_reg <= {16'h0, calh_reg};
				A_SPAN:  rdata_reg <= {16'h0, span_reg};
				A_MON:   rdata_reg <= {24'h0, mon2_reg, mon1_reg};
				A_PCT:   rdata_reg <= {mv_reg, pvp_reg};
				A_OUT:   rdata_reg <= {sp_reg - pvp_reg, cur_reg};
				A_TIME:  rdata_reg <= {12'h0, gidx_reg, gtime_reg};
				default: rdata_reg <= (avs_req.address[7:6] == A_TBL[7:6]) ?
					tbl_mem[avs_req.address[5:2]] : 32'h0;
			endcase
		end
	end
endmodule // poc_top

// ---- verification/poc_props.sv ----
// Port assertions for the PID output controller.
`timescale 1ns/100ps
module poc_props
	import poc_pkg::*;
#(
	parameter int SAMPLE_CYCLES = 8
) (
	input wire logic         mclk,
	input wire logic         rstn,
	input wire poc_avs_req_t avs_req,
	input wire logic         avs_waitrequest,
	input wire logic [15:0]  manipulated_output,
	input wire logic [15:0]  loop_current_ua,
	input wire logic         mode_manual,
	input wire logic [3:0]   monitor_function,
	input wire logic [15:0]  monitor_value
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	int          gap_reg;
	logic [15:0] mv_prev_reg;
	// Counts cycles since the output last moved, saturating at one sample period.
	always_ff @(posedge mclk) begin
		mv_prev_reg <= manipulated_output;
		if (!rstn)
			gap_reg <= SAMPLE_CYCLES;
		else if (manipulated_output != mv_prev_reg)
			gap_reg <= 1;
		else if (gap_reg < SAMPLE_CYCLES)
			gap_reg <= gap_reg + 1;
	end
	bus_wait_a: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("request waited more than one cycle");
	idle_nowait_a: assert property (!avs_req.read && !avs_req.write |-> !avs_waitrequest)
		else $error("waitrequest high without a request");
	current_map_a: assert property ({16'h0000, loop_current_ua} ==
		{16'h0000, CUR_LOW_UA} + {16'h0000, manipulated_output} * CUR_NUM / CUR_DEN)
		else $error("loop current does not match output percent");
	mv_ceiling_a: assert property (manipulated_output <= PCT_FULL)
		else $error("output percent above full scale");
	current_span_a: assert property (loop_current_ua >= CUR_LOW_UA && loop_current_ua <= 16'h4E20)
		else $error("loop current outside its span");
	sample_pace_a: assert property (manipulated_output != mv_prev_reg |-> gap_reg >= SAMPLE_CYCLES)
		else $error("output moved before a full sample period");
	monitor_mv_a: assert property ((monitor_function == MON_MV && $stable(manipulated_output))[*3]
		|-> monitor_value == manipulated_output) else $error("monitor does not show output");
	mode_hold_a: assert property (!avs_req.write && $past(rstn) |=> mode_manual == $past(mode_manual))
		else $error("mode changed without a write");
	cover property (monitor_function == MON_ERR);
	cover property ($rose(mode_manual));
	cover property (manipulated_output == 16'h1F40);
endmodule // poc_props

// ---- verification/poc_loop_rx.sv ----
// Current-loop receiver model that reads the loop back as percent of span.
`timescale 1ns/100ps
module poc_loop_rx (
	input  wire logic [15:0] loop_current_ua,
	input  wire logic        mclk,
	output logic      [15:0] loop_current_reading,
	output logic      [15:0] rx_percent
);
	always_ff @(posedge mclk) begin
		loop_current_reading <= loop_current_ua;
		rx_percent <= 16'(({16'h0000, loop_current_ua} - 32'h0FA0) * 5 / 8);
	end
endmodule // poc_loop_rx

// ---- verification/poc_top_tb.sv ----
// Self-checking bench of the PID output controller through its register bus.
`timescale 1ns/100ps
module poc_top_tb;
	import poc_pkg::*;
	logic         mclk, rstn, sensor_fail, nv_manual, avs_waitrequest, mode_manual;
	poc_avs_req_t avs_req;
	logic [1:0]   nv_pwr_mode;
	logic [3:0]   monitor_function;
	logic [15:0]  process_value, room_temp, manipulated_output, loop_current_ua, monitor_value;
	logic [15:0]  rx_reading, rx_percent, seen_mask;
	logic [31:0]  avs_readdata, rd;
	logic [15:0]  man_in [3] = '{16'h0BB8, 16'h2328, 16'h03E8};
	logic [15:0]  man_exp [3] = '{16'h0BB8, 16'h1F40, 16'h07D0};
	int           n_mismatch, num_checks;
	poc_top #(.SAMPLE_CYCLES(8), .MIN_SAMPLES(4), .SHOW_TICKS(3)) i_dut (.mclk(mclk),
		.rstn(rstn), .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .process_value(process_value), .room_temp(room_temp),
		.sensor_fail(sensor_fail), .nv_pwr_mode(nv_pwr_mode), .nv_manual(nv_manual),
		.mode_manual(mode_manual), .manipulated_output(manipulated_output),
		.loop_current_ua(loop_current_ua), .monitor_function(monitor_function),
		.monitor_value(monitor_value));
	poc_loop_rx i_rx (.loop_current_ua(loop_current_ua), .mclk(mclk),
		.loop_current_reading(rx_reading), .rx_percent(rx_percent));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Holds the request until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int g;
		g = 0;
		@(posedge mclk);
		avs_req <= '{read: !wr, write: wr, address: a, writedata: d};
		do begin
			@(posedge mclk);
			g++;
		end while (avs_waitrequest !== 1'b0 && g < 20);
		if (g >= 20) begin
			n_mismatch++;
			test_done();
		end
		rd = avs_readdata;
		avs_req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic watch();
		wait_cyc(40);
		seen_mask = '0;
		repeat (120) begin
			@(posedge mclk);
			seen_mask[monitor_function] = 1'b1;
		end
	endtask
	task automatic reset_dut(input logic [1:0] pm);
		@(posedge mclk);
		nv_pwr_mode <= pm;
		rstn <= 1'b0;
		wait_cyc(2);
		rstn <= 1'b1;
		wait_cyc(2);
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		wait_cyc(6000);
		n_mismatch++;
		test_done();
	end
	initial begin
		n_mismatch = 0;
		num_checks = 0;
		avs_req = '0;
		rstn = 1'b0;
		sensor_fail = 1'b0;
		nv_manual = 1'b1;
		nv_pwr_mode = 2'h0;
		process_value = 16'h0032;
		room_temp = 16'h0019;
		for (int m = 2; m >= 0; m--) begin
			reset_dut(2'(m));
			chk("power-up mode", {31'h0, mode_manual}, {31'h0, m != 0});
		end
		rd_chk(A_STAT, 32'h0000_0004, "status after power-up");
		rd_chk(A_KP, 32'h0000_0100, "gain reset");
		rd_chk(A_CALL, 32'h0000_F060, "calibration low reset");
		rd_chk(8'h7C, 32'h0, "unmapped read");
		wr(A_CTRL, 32'h0);
		rd_chk(A_STAT, 32'h0, "status after control write");
		for (int i = 0; i < 3; i++) begin
			process_value <= 16'(i * 32'h32);
			wait_cyc(40);
			chk("transmitter output", manipulated_output, i * 32'h1388);
			chk("loop current", loop_current_ua, 32'h0FA0 + i * 32'h1F40);
			chk("receiver percent", rx_percent, i * 32'h1388);
			chk("receiver reading", rx_reading, 32'h0FA0 + i * 32'h1F40);
		end
		wr(A_MON, 32'h05);
		wait_cyc(40);
		chk("monitor code", monitor_function, 32'h5);
		chk("monitor percent", monitor_value, 32'h2710);
		wr(A_MON, 32'h09);
		wait_cyc(20);
		chk("control-only code refused", monitor_function, 32'h5);
		wr(A_LOL, 32'h07D0);
		wr(A_HIL, 32'h1F40);
		wr(A_CTRL, 32'h05);
		for (int i = 0; i < 3; i++) begin
			wr(A_MAN, {16'h0, man_in[i]});
			wait_cyc(40);
			chk("manual output", manipulated_output, man_exp[i]);
		end
		chk("manual flag", mode_manual, 32'h1);
		process_value <= 16'h003C;
		wr(A_CTRL, 32'h0D);
		wait_cyc(40);
		rd_chk(A_SP, 32'h1770, "tracked setpoint");
		wr(A_CTRL, 32'h09);
		process_value <= 16'h001E;
		wait_cyc(40);
		rd_chk(A_SP, 32'h1770, "setpoint held in auto");
		chk("auto flag", mode_manual, 32'h0);
		wr(A_MON, 32'h09);
		wait_cyc(40);
		chk("error code", monitor_function, 32'h9);
		chk("error percent", monitor_value, 32'h0BB8);
		wr(A_MON, 32'h35);
		watch();
		chk("alternating codes", seen_mask, 32'h0028);
		wr(A_MON, 32'h55);
		watch();
		chk("steady equal codes", seen_mask, 32'h0020);
		wr(A_MON, 32'h02);
		watch();
		chk("steady single code", seen_mask, 32'h0004);
		wr(A_SAFE, 32'h1194);
		sensor_fail <= 1'b1;
		wait_cyc(40);
		chk("safety output", manipulated_output, 32'h1194);
		bus(1'b0, A_STAT, 32'h0);
		chk("failure status", rd & 32'h6, 32'h6);
		sensor_fail <= 1'b0;
		wr(A_CTRL, 32'h31);
		bus(1'b0, A_CTRL, 32'h0);
		chk("generator with linearization", rd & 32'h10, 32'h0);
		wr(A_CTRL, 32'h0);
		wr(A_TBL, 32'h0000_1234);
		wr(8'h84, 32'hFFFF_0000);
		wr(A_CTRL, 32'h11);
		wait_cyc(40);
		rd_chk(A_SP, 32'h1234, "generator setpoint");
		wr(A_CTRL, 32'h0);
		wr(A_LRV, 32'h5F);
		rd_chk(A_STAT, 32'h1, "narrow span refused");
		rd_chk(A_LRV, 32'h0, "lower kept");
		rd_chk(A_URV, 32'h64, "upper untouched");
		wr(A_STAT, 32'h1);
		wr(A_URV, 32'h1388);
		rd_chk(A_STAT, 32'h1, "beyond calibration refused");
		rd_chk(A_URV, 32'h64, "upper kept");
		wr(A_STAT, 32'h1);
		wr(A_LRV, 32'h59);
		wr(A_URV, 32'h0);
		wr(A_LRV, 32'h64);
		rd_chk(A_STAT, 32'h0, "reversal accepted");
		rd_chk(A_LRV, 32'h64, "reversed lower");
		rd_chk(A_URV, 32'h0, "reversed upper");
		process_value <= 16'h005A;
		wait_cyc(40);
		chk("reversed output", manipulated_output, 32'h03E8);
		test_done();
	end
endmodule // poc_top_tb
bind poc_top poc_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_props (.mclk(mclk), .rstn(rstn),
	.avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
	.manipulated_output(manipulated_output), .loop_current_ua(loop_current_ua),
	.mode_manual(mode_manual), .monitor_function(monitor_function),
	.monitor_value(monitor_value));
